//--- logic/pis_map.vh
// Register offsets, field positions, reset values and filter timing of the input sampler.
`ifndef PIS_MAP_VH
`define PIS_MAP_VH

`define PIS_CLK_MHZ            125
`define PIS_T_SLOW_US          3000
`define PIS_T_FAST_US          100
`define PIS_T_NEAR_US          500
`define PIS_T_ZPH_US           50

`define PIS_OFS_CTRL           8'h00
`define PIS_OFS_ROLE           8'h04
`define PIS_OFS_CMD            8'h08
`define PIS_OFS_STATUS         8'h0C
`define PIS_OFS_SHARED         8'h10
`define PIS_OFS_RELAY          8'h14
`define PIS_OFS_RELAY_SEEN     8'h18
`define PIS_OFS_MPG_COUNT      8'h1C

`define PIS_CTRL_MANUAL        0
`define PIS_CTRL_RUNNING       1
`define PIS_CTRL_ZRN_ACTIVE    2
`define PIS_CTRL_END_STANDBY   3
`define PIS_CTRL_READY_STATE   4
`define PIS_CTRL_MPG_IN_USE    5
`define PIS_CTRL_INT_INSTR     6
`define PIS_CTRL_SINGLE_INT    7
`define PIS_CTRL_DUAL_INT      8
`define PIS_CTRL_W             9
`define PIS_CTRL_RESET         9'h001

`define PIS_CMD_BEFORE_DRIVE   0
`define PIS_CMD_AFTER_DRIVE    1
`define PIS_CMD_GENERAL_READ   2

`define PIS_STAT_CHECK_OK      11
`define PIS_STAT_DOG_SEEN      12

`define PIS_RESP_OKAY          2'h0
`define PIS_RESP_SLVERR        2'h2

`endif

//--- logic/pis_sampler.v
// Input filtering and fetch-timing logic of the positioning unit, with its AXI4-Lite registers.
// Operation
// - Command, limit, drive-ready and in-position inputs pass a filter of about 3 ms.
// - Each shared pin gets a 3 ms filter as a general input and 0.1 ms as pulse or interrupt input.
// - Shared pins act as interrupt sources only on the two-axis variant.
// - The zero-phase marker is sampled only while running and after the near-point switch acted.
// - The near-point switch is read before a zero-return drive and watched during zero return.
// - In automatic mode while stopped, zero return and jog are accepted only in end standby.
// - In automatic mode while stopped, shared inputs are read with the pulse generator in use or in end standby.
// - In automatic mode while running, shared inputs are read only during interrupt-driven moves.
// - General inputs are read only when the referencing instruction executes in automatic mode.
// - Inputs given a dedicated function are monitored continuously in automatic mode.
// - Software command relays are monitored continuously in automatic mode.
// - General inputs used as ordinary inputs pass a filter of about 3 ms.
`timescale 1ns/1ps
`default_nettype none
`include "pis_map.vh"

module pis_sampler #(
   parameter        TWO_AXIS    = 1,
   parameter [19:0] SLOW_CYCLES = `PIS_T_SLOW_US * `PIS_CLK_MHZ,
   parameter [19:0] FAST_CYCLES = `PIS_T_FAST_US * `PIS_CLK_MHZ,
   parameter [19:0] NEAR_CYCLES = `PIS_T_NEAR_US * `PIS_CLK_MHZ,
   parameter [19:0] ZPH_CYCLES  = `PIS_T_ZPH_US * `PIS_CLK_MHZ
) (
   input  wire        CLK,
   input  wire        SYS_RST,
   input  wire        START,
   input  wire        STOP,
   input  wire        ZERO_RETURN_CMD,
   input  wire        JOG_FORWARD,
   input  wire        JOG_REVERSE,
   input  wire        FORWARD_LIMIT,
   input  wire        REVERSE_LIMIT,
   input  wire        DRIVE_READY,
   input  wire        DRIVE_IN_POSITION,
   input  wire        NEAR_POINT_SWITCH,
   input  wire        ZERO_PHASE_MARKER,
   input  wire [7:0]  SHARED_INPUTS,
   output reg  [7:0]  INTERRUPT_EVENT,
   input  wire [7:0]  S_AXI_AWADDR,
   input  wire        S_AXI_AWVALID,
   output reg         S_AXI_AWREADY,
   input  wire [31:0] S_AXI_WDATA,
   input  wire [3:0]  S_AXI_WSTRB,
   input  wire        S_AXI_WVALID,
   output reg         S_AXI_WREADY,
   output reg  [1:0]  S_AXI_BRESP,
   output reg         S_AXI_BVALID,
   input  wire        S_AXI_BREADY,
   input  wire [7:0]  S_AXI_ARADDR,
   input  wire        S_AXI_ARVALID,
   output reg         S_AXI_ARREADY,
   output reg  [31:0] S_AXI_RDATA,
   output reg  [1:0]  S_AXI_RRESP,
   output reg         S_AXI_RVALID,
   input  wire        S_AXI_RREADY
);

   localparam NCH      = 19;
   localparam CH_ZRN   = 2;
   localparam CH_FWD   = 3;
   localparam CH_RVS   = 4;
   localparam CH_LSF   = 5;
   localparam CH_LSR   = 6;
   localparam CH_RDY   = 7;
   localparam CH_INPOS = 8;
   localparam CH_DOG   = 9;
   localparam CH_ZPH   = 10;
   localparam CH_SH    = 11;
   localparam [1:0] CLS_SLOW = 2'h0;
   localparam [1:0] CLS_FAST = 2'h1;
   localparam [1:0] CLS_NEAR = 2'h2;
   localparam [1:0] CLS_ZPH  = 2'h3;

   function [19:0] filter_limit;
      input [1:0] cls;
      begin
         case (cls)
            CLS_FAST: filter_limit = FAST_CYCLES;
            CLS_NEAR: filter_limit = NEAR_CYCLES;
            CLS_ZPH:  filter_limit = ZPH_CYCLES;
            default:  filter_limit = SLOW_CYCLES;
         endcase
      end
   endfunction

   function [31:0] merge_word;
      input [31:0] old;
      input [31:0] data;
      input [3:0]  strb;
      integer      b;
      begin
         merge_word = old;
         for (b = 0; b < 4; b = b + 1) begin
            if (strb[b]) begin
               merge_word[b*8 +: 8] = data[b*8 +: 8];
            end
         end
      end
   endfunction

   reg  [`PIS_CTRL_W-1:0] ctrl;
   reg  [31:0]            role;
   reg  [7:0]             relay;
   reg  [7:0]             relay_seen;
   reg  [2:0]             cmd;
   reg  [10:0]            acc;
   reg                    check_ok;
   reg                    dog_seen;
   reg  [7:0]             shared_acc;
   reg  [7:0]             general_snap;
   reg  [7:0]             dedicated_mon;
   reg  [15:0]            mpg_count;
   reg  [NCH-1:0]         s1;
   reg  [NCH-1:0]         s2;
   reg  [NCH-1:0]         s3;
   reg  [NCH-1:0]         filt;
   reg  [NCH-1:0]         filt_d;
   reg  [19:0]            cnt [0:NCH-1];
   reg  [7:0]             aw_addr;
   reg                    aw_got;
   reg  [31:0]            w_data;
   reg  [3:0]             w_strb;
   reg                    w_got;
   reg  [31:0]            next_rdata;
   reg  [1:0]             next_rresp;
   reg  [1:0]             ch_cls [0:NCH-1];
   integer                i;
   integer                j;

   wire [NCH-1:0] raw = {SHARED_INPUTS, ZERO_PHASE_MARKER, NEAR_POINT_SWITCH, DRIVE_IN_POSITION,
                         DRIVE_READY, REVERSE_LIMIT, FORWARD_LIMIT, JOG_REVERSE, JOG_FORWARD,
                         ZERO_RETURN_CMD, STOP, START};
   wire       manual   = ctrl[`PIS_CTRL_MANUAL];
   wire       auto_m   = ~ctrl[`PIS_CTRL_MANUAL];
   wire       running  = ctrl[`PIS_CTRL_RUNNING];
   wire       stopped  = ~ctrl[`PIS_CTRL_RUNNING];
   wire       zrn_act  = ctrl[`PIS_CTRL_ZRN_ACTIVE];
   wire       end_sb   = ctrl[`PIS_CTRL_END_STANDBY];
   wire       mpg_use  = ctrl[`PIS_CTRL_MPG_IN_USE];
   wire       int_move = ctrl[`PIS_CTRL_INT_INSTR] | ctrl[`PIS_CTRL_SINGLE_INT] |
                         ctrl[`PIS_CTRL_DUAL_INT];
   wire [7:0] role_pulse = role[7:0];
   wire [7:0] role_int   = (TWO_AXIS != 0) ? role[15:8] : 8'h00;
   wire [7:0] role_ded   = role[23:16];
   wire [7:0] sh_filt    = filt[NCH-1:CH_SH];
   wire [7:0] sh_rise    = filt[NCH-1:CH_SH] & ~filt_d[NCH-1:CH_SH];
   wire       sh_read    = manual ? mpg_use :
                           (stopped ? (mpg_use | end_sb) : int_move);
   wire       do_write   = aw_got & w_got & ~S_AXI_BVALID;
   wire [31:0] ctrl_merged = merge_word({23'h000000, ctrl}, w_data, w_strb);

   always @* begin
      for (j = 0; j < CH_DOG; j = j + 1) begin
         ch_cls[j] = CLS_SLOW;
      end
      ch_cls[CH_DOG] = CLS_NEAR;
      ch_cls[CH_ZPH] = CLS_ZPH;
      for (j = 0; j < 8; j = j + 1) begin
         ch_cls[CH_SH+j] = (role_pulse[j] | role_int[j]) ? CLS_FAST : CLS_SLOW;
      end
   end

   // Three-stage synchroniser; a level counts once stages two and three agree and hold.
   always @(posedge CLK) begin
      if (SYS_RST) begin
         s1     <= {NCH{1'b0}};
         s2     <= {NCH{1'b0}};
         s3     <= {NCH{1'b0}};
         filt   <= {NCH{1'b0}};
         filt_d <= {NCH{1'b0}};
         for (i = 0; i < NCH; i = i + 1) begin
            cnt[i] <= 20'h00000;
         end
      end else begin
         s1     <= raw;
         s2     <= s1;
         s3     <= s2;
         filt_d <= filt;
         for (i = 0; i < NCH; i = i + 1) begin
            if (s2[i] != s3[i] || s3[i] == filt[i]) begin
               cnt[i] <= 20'h00000;
            end else if (cnt[i] + 20'h00001 >= filter_limit(ch_cls[i])) begin
               cnt[i]  <= 20'h00000;
               filt[i] <= s3[i];
            end else begin
               cnt[i] <= cnt[i] + 20'h00001;
            end
         end
      end
   end

   // Fetch timing of each input by mode and motor state.
   always @(posedge CLK) begin
      if (SYS_RST) begin
         acc             <= 11'h000;
         check_ok        <= 1'b0;
         dog_seen        <= 1'b0;
         shared_acc      <= 8'h00;
         general_snap    <= 8'h00;
         dedicated_mon   <= 8'h00;
         relay_seen      <= 8'h00;
         mpg_count       <= 16'h0000;
         INTERRUPT_EVENT <= 8'h00;
      end else begin
         acc[1] <= filt[1];
         if (auto_m & stopped & ctrl[`PIS_CTRL_READY_STATE]) begin
            acc[0] <= filt[0];
         end
         if ((manual & stopped) | (auto_m & stopped & end_sb)) begin
            acc[CH_ZRN] <= filt[CH_ZRN];
         end
         if (manual | (stopped & end_sb)) begin
            acc[CH_FWD] <= filt[CH_FWD];
            acc[CH_RVS] <= filt[CH_RVS];
         end
         if (running | (stopped & cmd[`PIS_CMD_BEFORE_DRIVE])) begin
            acc[CH_LSF] <= filt[CH_LSF];
            acc[CH_LSR] <= filt[CH_LSR];
            acc[CH_RDY] <= filt[CH_RDY];
         end
         if (stopped & cmd[`PIS_CMD_BEFORE_DRIVE]) begin
            check_ok <= filt[CH_RDY] & ~filt[CH_LSF] & ~filt[CH_LSR];
         end
         if (stopped & cmd[`PIS_CMD_AFTER_DRIVE]) begin
            acc[CH_INPOS] <= filt[CH_INPOS];
         end
         if ((stopped & cmd[`PIS_CMD_BEFORE_DRIVE]) | (running & zrn_act)) begin
            acc[CH_DOG] <= filt[CH_DOG];
         end
         if (stopped) begin
            dog_seen <= 1'b0;
         end else if (zrn_act & filt[CH_DOG]) begin
            dog_seen <= 1'b1;
         end
         if (running & dog_seen) begin
            acc[CH_ZPH] <= filt[CH_ZPH];
         end
         if (sh_read) begin
            shared_acc <= sh_filt;
         end
         if (auto_m & cmd[`PIS_CMD_GENERAL_READ]) begin
            general_snap <= sh_filt & ~role_pulse & ~role_int;
         end
         if (auto_m) begin
            dedicated_mon <= sh_filt & role_ded;
            relay_seen    <= relay;
         end
         if (sh_read & |(sh_rise & role_pulse)) begin
            mpg_count <= mpg_count + 16'h0001;
         end
         INTERRUPT_EVENT <= (auto_m & running & int_move) ? (sh_rise & role_int) : 8'h00;
      end
   end

   always @* begin
      next_rresp = `PIS_RESP_OKAY;
      next_rdata = 32'h00000000;
      case (S_AXI_ARADDR)
         `PIS_OFS_CTRL:       next_rdata = {23'h000000, ctrl};
         `PIS_OFS_ROLE:       next_rdata = role;
         `PIS_OFS_CMD:        next_rdata = 32'h00000000;
         `PIS_OFS_STATUS:     next_rdata = {19'h00000, dog_seen, check_ok, acc};
         `PIS_OFS_SHARED:     next_rdata = {8'h00, dedicated_mon, general_snap, shared_acc};
         `PIS_OFS_RELAY:      next_rdata = {24'h000000, relay};
         `PIS_OFS_RELAY_SEEN: next_rdata = {24'h000000, relay_seen};
         `PIS_OFS_MPG_COUNT:  next_rdata = {16'h0000, mpg_count};
         default:             next_rresp = `PIS_RESP_SLVERR;
      endcase
   end

   // AXI4-Lite slave: address and data are held separately, the write lands one edge later.
   always @(posedge CLK) begin
      if (SYS_RST) begin
         S_AXI_AWREADY <= 1'b0;
         S_AXI_WREADY  <= 1'b0;
         S_AXI_BVALID  <= 1'b0;
         S_AXI_BRESP   <= `PIS_RESP_OKAY;
         S_AXI_ARREADY <= 1'b0;
         S_AXI_RVALID  <= 1'b0;
         S_AXI_RDATA   <= 32'h00000000;
         S_AXI_RRESP   <= `PIS_RESP_OKAY;
         aw_got        <= 1'b0;
         w_got         <= 1'b0;
         aw_addr       <= 8'h00;
         w_data        <= 32'h00000000;
         w_strb        <= 4'h0;
         ctrl          <= `PIS_CTRL_RESET;
         role          <= 32'h00000000;
         relay         <= 8'h00;
         cmd           <= 3'h0;
      end else begin
         cmd <= 3'h0;
         if (S_AXI_AWVALID & S_AXI_AWREADY) begin
            aw_got        <= 1'b1;
            aw_addr       <= S_AXI_AWADDR;
            S_AXI_AWREADY <= 1'b0;
         end else begin
            S_AXI_AWREADY <= ~aw_got & ~S_AXI_BVALID & ~do_write;
         end
         if (S_AXI_WVALID & S_AXI_WREADY) begin
            w_got        <= 1'b1;
            w_data       <= S_AXI_WDATA;
            w_strb       <= S_AXI_WSTRB;
            S_AXI_WREADY <= 1'b0;
         end else begin
            S_AXI_WREADY <= ~w_got & ~S_AXI_BVALID & ~do_write;
         end
         if (do_write) begin
            aw_got       <= 1'b0;
            w_got        <= 1'b0;
            S_AXI_BVALID <= 1'b1;
            S_AXI_BRESP  <= `PIS_RESP_OKAY;
            case (aw_addr)
               `PIS_OFS_CTRL:  ctrl  <= ctrl_merged[`PIS_CTRL_W-1:0];
               `PIS_OFS_ROLE:  role  <= merge_word(role, w_data, w_strb);
               `PIS_OFS_CMD:   cmd   <= w_strb[0] ? w_data[2:0] : 3'h0;
               `PIS_OFS_RELAY: relay <= w_strb[0] ? w_data[7:0] : relay;
               `PIS_OFS_STATUS, `PIS_OFS_SHARED, `PIS_OFS_RELAY_SEEN,
               `PIS_OFS_MPG_COUNT: S_AXI_BRESP <= `PIS_RESP_OKAY;
               default:        S_AXI_BRESP <= `PIS_RESP_SLVERR;
            endcase
         end else if (S_AXI_BVALID & S_AXI_BREADY) begin
            S_AXI_BVALID <= 1'b0;
         end
         if (S_AXI_ARVALID & S_AXI_ARREADY) begin
            S_AXI_ARREADY <= 1'b0;
            S_AXI_RVALID  <= 1'b1;
            S_AXI_RDATA   <= next_rdata;
            S_AXI_RRESP   <= next_rresp;
         end else if (S_AXI_RVALID) begin
            if (S_AXI_RREADY) begin
               S_AXI_RVALID <= 1'b0;
            end
         end else begin
            S_AXI_ARREADY <= 1'b1;
         end
      end
   end

endmodule // pis_sampler
`default_nettype wire

//--- verif/pis_checker.sv
// Port-level assertions for the positioning input sampler.
`timescale 1ns/1ps
`default_nettype none
`include "pis_map.vh"
module pis_checker #(
   parameter TWO_AXIS = 1
) (
   input wire logic        CLK,
   input wire logic        SYS_RST,
   input wire logic [7:0]  SHARED_INPUTS,
   input wire logic [7:0]  INTERRUPT_EVENT,
   input wire logic [7:0]  S_AXI_AWADDR,
   input wire logic        S_AXI_AWVALID,
   input wire logic        S_AXI_AWREADY,
   input wire logic [1:0]  S_AXI_BRESP,
   input wire logic        S_AXI_BVALID,
   input wire logic        S_AXI_BREADY,
   input wire logic [7:0]  S_AXI_ARADDR,
   input wire logic        S_AXI_ARVALID,
   input wire logic        S_AXI_ARREADY,
   input wire logic [31:0] S_AXI_RDATA,
   input wire logic [1:0]  S_AXI_RRESP,
   input wire logic        S_AXI_RVALID,
   input wire logic        S_AXI_RREADY
);
   default clocking cb @(posedge CLK); endclocking
   default disable iff (SYS_RST);
   a_reset_quiet: assert property (disable iff (1'b0) SYS_RST |=> !S_AXI_BVALID
      && !S_AXI_RVALID && INTERRUPT_EVENT == 8'h00) else $error("output active in reset");
   a_bresp_held: assert property (S_AXI_BVALID && !S_AXI_BREADY |=> S_AXI_BVALID
      && $stable(S_AXI_BRESP)) else $error("write response dropped early");
   a_rdata_held: assert property (S_AXI_RVALID && !S_AXI_RREADY |=> S_AXI_RVALID
      && $stable(S_AXI_RDATA)) else $error("read data dropped early");
   a_read_answer: assert property (S_AXI_ARVALID && S_AXI_ARREADY |=> S_AXI_RVALID
      && !S_AXI_ARREADY) else $error("read not answered next cycle");
   a_read_unmapped: assert property (S_AXI_ARVALID && S_AXI_ARREADY && S_AXI_ARADDR > 8'h1C
      |=> S_AXI_RRESP == `PIS_RESP_SLVERR && S_AXI_RDATA == 32'h0) else $error("bad read ok");
   a_write_unmapped: assert property (S_AXI_AWVALID && S_AXI_AWREADY && S_AXI_AWADDR > 8'h1C
      |-> ##[1:20] (S_AXI_BVALID && S_AXI_BRESP == `PIS_RESP_SLVERR))
      else $error("bad write ok");
   a_irq_pulse:
      assert property ((INTERRUPT_EVENT & $past(INTERRUPT_EVENT)) == 8'h00)
      else $error("interrupt event longer than one cycle");
   a_irq_variant:
      assert property (INTERRUPT_EVENT != 8'h00 |-> TWO_AXIS != 0)
      else $error("interrupt event on small variant");
   a_irq_cause:
      assert property (INTERRUPT_EVENT[0] |-> $past(SHARED_INPUTS[0], 4))
      else $error("interrupt event without filtered pin");
endmodule // pis_checker
bind pis_sampler pis_checker #(.TWO_AXIS(TWO_AXIS)) pis_checker_inst (.CLK, .SYS_RST,
   .SHARED_INPUTS, .INTERRUPT_EVENT, .S_AXI_AWADDR, .S_AXI_AWVALID, .S_AXI_AWREADY,
   .S_AXI_BRESP, .S_AXI_BVALID, .S_AXI_BREADY, .S_AXI_ARADDR, .S_AXI_ARVALID,
   .S_AXI_ARREADY, .S_AXI_RDATA, .S_AXI_RRESP, .S_AXI_RVALID, .S_AXI_RREADY);
`default_nettype wire

//--- verif/pis_field_model.sv
// Hand pulse generator on the far side of the input sampler.
`timescale 1ns/1ps
`default_nettype none
module pis_field_model #(
   parameter int HALF = 31250
) (
   input  wire logic clk,
   output var logic  mpg
);
   initial mpg = 1'b0;
   // High and low phases never go below HALF cycles, which caps the pulse rate.
   task automatic pulses(input int n);
      repeat (n) begin
         repeat (HALF) @(posedge clk);
         mpg <= 1'b1;
         repeat (HALF) @(posedge clk);
         mpg <= 1'b0;
      end
   endtask
endmodule // pis_field_model
`default_nettype wire

//--- verif/test_positioning_input_sampler.sv
// Self-checking bench of the positioning input sampler.
`timescale 1ns/1ps
`default_nettype none
`include "pis_map.vh"
module test_positioning_input_sampler;
   localparam int SETTLE = 14;
   localparam logic [1:0] OK = `PIS_RESP_OKAY;
   logic        clk = 1'b0;
   logic        rst = 1'b1;
   logic [10:0] pin = 11'h0;
   logic [7:0]  sh = 8'h0, awa = 8'h0, ara = 8'h0;
   logic [31:0] wd = 32'h0, v;
   logic [3:0]  ws = 4'h0, wstr = 4'hF;
   logic        awv = 1'b0, wv = 1'b0, bre = 1'b0, arv = 1'b0, rre = 1'b0;
   logic        awr, wrd, bv, arr, rv, mpg;
   logic [7:0]  irq;
   logic [1:0]  br, rr;
   logic [31:0] rdat;
   int          n_errors = 0;
   int          compares = 0;
   int          n_irq = 0;
   always #4 clk = ~clk;
   always @(negedge clk) if (irq[0] === 1'b1) n_irq <= n_irq + 1;
   pis_sampler #(.SLOW_CYCLES(20'h8), .FAST_CYCLES(20'h2),
      .NEAR_CYCLES(20'h4), .ZPH_CYCLES(20'h3)) pis_sampler_inst (.CLK(clk), .SYS_RST(rst),
      .START(pin[0]), .STOP(pin[1]), .ZERO_RETURN_CMD(pin[2]), .JOG_FORWARD(pin[3]),
      .JOG_REVERSE(pin[4]), .FORWARD_LIMIT(pin[5]), .REVERSE_LIMIT(pin[6]),
      .DRIVE_READY(pin[7]), .DRIVE_IN_POSITION(pin[8]), .NEAR_POINT_SWITCH(pin[9]),
      .ZERO_PHASE_MARKER(pin[10]), .SHARED_INPUTS({sh[7:1], sh[0] | mpg}),
      .INTERRUPT_EVENT(irq), .S_AXI_AWADDR(awa), .S_AXI_AWVALID(awv), .S_AXI_AWREADY(awr),
      .S_AXI_WDATA(wd), .S_AXI_WSTRB(ws), .S_AXI_WVALID(wv), .S_AXI_WREADY(wrd),
      .S_AXI_BRESP(br), .S_AXI_BVALID(bv), .S_AXI_BREADY(bre), .S_AXI_ARADDR(ara),
      .S_AXI_ARVALID(arv), .S_AXI_ARREADY(arr), .S_AXI_RDATA(rdat), .S_AXI_RRESP(rr),
      .S_AXI_RVALID(rv), .S_AXI_RREADY(rre));
   pis_field_model #(.HALF(6)) pis_field_model_inst (.clk(clk), .mpg(mpg));
   task automatic chk_d(input logic [31:0] got, input logic [31:0] exp);
      compares++;
      if (got !== exp) begin
         n_errors++;
         $display("mismatch at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic chk_r(input logic [1:0] got, input logic [1:0] exp);
      chk_d({30'h0, got}, {30'h0, exp});
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] e);
      logic ah, wh, done;
      logic [1:0] r;
      done = 1'b0;
      awa <= a;
      wd <= d;
      ws <= wstr;
      awv <= 1'b1;
      wv <= 1'b1;
      bre <= 1'b1;
      while (!done) begin
         @(negedge clk);
         ah = awv && awr;
         wh = wv && wrd;
         done = bv;
         r = br;
         @(posedge clk);
         if (ah) awv <= 1'b0;
         if (wh) wv <= 1'b0;
      end
      bre <= 1'b0;
      @(posedge clk);
      chk_r(r, e);
   endtask
   task automatic rd(input logic [7:0] a, input logic [31:0] e, input logic [1:0] er);
      logic ah, done;
      logic [31:0] d;
      logic [1:0] r;
      done = 1'b0;
      ara <= a;
      arv <= 1'b1;
      rre <= 1'b1;
      while (!done) begin
         @(negedge clk);
         ah = arv && arr;
         done = rv;
         d = rdat;
         r = rr;
         @(posedge clk);
         if (ah) arv <= 1'b0;
      end
      rre <= 1'b0;
      @(posedge clk);
      chk_d(d, e);
      chk_r(r, er);
   endtask
   task automatic st(input logic [10:0] p, input logic [8:0] c, input logic [2:0] k,
                     input logic [31:0] e);
      pin <= p;
      wr(`PIS_OFS_CTRL, {23'h0, c}, OK);
      repeat (SETTLE) @(posedge clk);
      if (k != 3'h0) wr(`PIS_OFS_CMD, {29'h0, k}, OK);
      rd(`PIS_OFS_STATUS, e, OK);
   endtask
   task automatic finish_test;
      $display("compares %0d n_errors %0d", compares, n_errors);
      if (n_errors == 0 && compares > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask
   initial begin
      repeat (30000) @(posedge clk);
      n_errors++;
      finish_test();
   end
   initial begin
      v = $urandom(32'h65B9);
      repeat (12) @(posedge clk);
      rst <= 1'b0;
      @(posedge clk);
      v = $urandom;
      rd(`PIS_OFS_CTRL, {23'h0, `PIS_CTRL_RESET}, OK);
      rd(`PIS_OFS_ROLE, 32'h0, OK);
      rd(`PIS_OFS_CMD, 32'h0, OK);
      rd(8'h20, 32'h0, `PIS_RESP_SLVERR);
      wr(8'h24, v, `PIS_RESP_SLVERR);
      wr(`PIS_OFS_STATUS, v, OK);
      pin <= 11'h002;
      repeat (4) @(posedge clk);
      pin <= 11'h000;
      repeat (SETTLE) @(posedge clk);
      rd(`PIS_OFS_STATUS, 32'h0, OK);
      st(11'h002, 9'h001, 3'h0, 32'h002);
      st(11'h00C, 9'h000, 3'h0, 32'h000);
      st(11'h00C, 9'h008, 3'h0, 32'h00C);
      st(11'h400, 9'h006, 3'h0, 32'h00C);
      st(11'h600, 9'h006, 3'h0, 32'h160C);
      st(11'h080, 9'h000, 3'h1, 32'hC8C);
      st(11'h100, 9'h000, 3'h2, 32'hD8C);
      st(11'h020, 9'h000, 3'h1, 32'h52C);
      st(11'h001, 9'h010, 3'h0, 32'h52D);
      st(11'h051, 9'h001, 3'h1, 32'h551);
      wr(`PIS_OFS_ROLE, 32'h00F0_0000, OK);
      wr(`PIS_OFS_CTRL, 32'h008, OK);
      sh <= v[7:0];
      repeat (SETTLE) @(posedge clk);
      rd(`PIS_OFS_SHARED, {8'h0, v[7:0] & 8'hF0, 8'h0, v[7:0]}, OK);
      wr(`PIS_OFS_CMD, 32'h4, OK);
      rd(`PIS_OFS_SHARED, {8'h0, v[7:0] & 8'hF0, v[7:0], v[7:0]}, OK);
      wr(`PIS_OFS_CTRL, 32'h0, OK);
      sh <= ~v[7:0];
      repeat (SETTLE) @(posedge clk);
      rd(`PIS_OFS_SHARED, {8'h0, ~v[7:0] & 8'hF0, v[7:0], v[7:0]}, OK);
      wr(`PIS_OFS_CTRL, 32'h1, OK);
      wr(`PIS_OFS_CMD, 32'h4, OK);
      rd(`PIS_OFS_SHARED, {8'h0, ~v[7:0] & 8'hF0, v[7:0], v[7:0]}, OK);
      wr(`PIS_OFS_CTRL, 32'h0, OK);
      wr(`PIS_OFS_RELAY, v, OK);
      rd(`PIS_OFS_RELAY_SEEN, {24'h0, v[7:0]}, OK);
      wr(`PIS_OFS_CTRL, 32'h1, OK);
      wr(`PIS_OFS_RELAY, ~v, OK);
      rd(`PIS_OFS_RELAY_SEEN, {24'h0, v[7:0]}, OK);
      rd(`PIS_OFS_RELAY, {24'h0, ~v[7:0]}, OK);
      wstr = 4'h2;
      wr(`PIS_OFS_ROLE, v, OK);
      wstr = 4'hF;
      rd(`PIS_OFS_ROLE, {8'h0, 8'hF0, v[15:8], 8'h0}, OK);
      sh <= 8'h00;
      wr(`PIS_OFS_ROLE, 32'h100, OK);
      wr(`PIS_OFS_CTRL, 32'h042, OK);
      repeat (SETTLE) @(posedge clk);
      pis_field_model_inst.pulses(4);
      repeat (SETTLE) @(posedge clk);
      chk_d(32'(n_irq), 32'h4);
      wr(`PIS_OFS_CTRL, 32'h002, OK);
      pis_field_model_inst.pulses(2);
      repeat (SETTLE) @(posedge clk);
      chk_d(32'(n_irq), 32'h4);
      wr(`PIS_OFS_ROLE, 32'h1, OK);
      wr(`PIS_OFS_CTRL, 32'h021, OK);
      pis_field_model_inst.pulses(3);
      repeat (SETTLE) @(posedge clk);
      rd(`PIS_OFS_MPG_COUNT, 32'h3, OK);
      finish_test();
   end
endmodule // test_positioning_input_sampler
`default_nettype wire
